// *** hw/smd_dec.sv ***
// Address decoder for one master in the processor view.
// Assumes the top module has already relocated DMA and USB addresses.
`timescale 1ns/1ps
`include "smd_defs.svh"
module smd_dec
    import smd_pkg::*;
(
    input wire logic [23:0] addr_i,
    input wire smd_mst_t who_i,
    input wire logic remap_i,
    smd_tgt_if.dec tgt
);
    logic [5:0] sar_idx;

    // Block index of single-access RAM counted from its base.
    assign sar_idx = addr_i[18:13] - `SMD_SAR_BLK0;

    // Region decode with the access limits of each master.
    always_comb begin
        tgt.kind = TK_NONE;
        tgt.blk = 5'h00;
        tgt.cs = 2'h0;
        if (addr_i < `SMD_MMR_END) begin
            tgt.kind = (who_i == MS_CPU) ? TK_MMR : TK_REF;
        end else if (addr_i < `SMD_DAR_END) begin
            tgt.kind = (who_i == MS_USB) ? TK_REF : TK_DAR;
            tgt.blk = {2'h0, addr_i[15:13]};
        end else if (addr_i < `SMD_SAR_END) begin
            tgt.kind = TK_SAR;
            tgt.blk = sar_idx[4:0];
        end else if (addr_i >= `SMD_ROM_BASE && !remap_i) begin
            // Only the processor buses see the ROM.
            tgt.kind = (who_i == MS_CPU) ? TK_ROM : TK_REF;
            tgt.blk = {3'h0, addr_i[16:15]};
        end else if (addr_i >= `SMD_CS2_BASE) begin
            tgt.kind = (who_i == MS_DMA) ? TK_REF : TK_EXT;
            // With the ROM gone its range falls into region five.
            if (addr_i >= `SMD_CS5_BASE) begin
                tgt.cs = 2'h3;
            end else if (addr_i >= `SMD_CS4_BASE) begin
                tgt.cs = 2'h2;
            end else if (addr_i >= `SMD_CS3_BASE) begin
                tgt.cs = 2'h1;
            end else begin
                tgt.cs = 2'h0;
            end
        end else begin
            tgt.kind = TK_NONE;
        end
    end
endmodule : smd_dec

// *** hw/smd_defs.svh ***
// Constants of the system memory map decoder: boundaries, block fields,
// relocation offsets and reset values.
// Assumes byte addresses: 24 bits for the processor, 32 bits for DMA/USB.
`ifndef SMD_DEFS_SVH
`define SMD_DEFS_SVH

// ****************************************************************
// Processor view boundaries
// ****************************************************************
`define SMD_MMR_END 24'h0000c0
`define SMD_DAR_END 24'h010000
`define SMD_SAR_END 24'h042000
`define SMD_CS2_BASE 24'h800000
`define SMD_CS3_BASE 24'hc00000
`define SMD_CS4_BASE 24'he00000
`define SMD_CS5_BASE 24'hf00000
`define SMD_ROM_BASE 24'hfe0000
`define SMD_GAP_ADDR 24'h060000
`define SMD_SAR_BLK0 6'h08

// ****************************************************************
// DMA and USB view boundaries
// ****************************************************************
`define SMD_DMA_DAR_BASE 32'h0001_0000
`define SMD_DMA_DAR_END 32'h0002_0000
`define SMD_DMA_SAR_BASE 32'h0009_0000
`define SMD_DMA_SAR_END 32'h000c_2000
`define SMD_DMA_SAR_OFS 24'h080000
`define SMD_DMA_EXT_BASE 32'h0200_0000
`define SMD_DMA_EXT_END 32'h0510_0000
`define SMD_DMA_EXT_ID 2'h3

// ****************************************************************
// Counts and reset values
// ****************************************************************
`define SMD_N_DAR 8
`define SMD_N_SAR 25
`define SMD_N_ROM 4
`define SMD_N_MST 4
`define SMD_REMAP_RST 1'b0

`endif

// *** hw/smd_pkg.sv ***
// Types of the system memory map decoder.
// Assumes smd_defs.svh for the numbers.
package smd_pkg;
    // Target kinds that a decoded address can select.
    typedef enum logic [2:0] {
        TK_NONE, TK_MMR, TK_DAR, TK_SAR, TK_ROM, TK_EXT, TK_REF
    } smd_kind_t;
    // Kind of master behind one decoder.
    typedef enum logic [1:0] {MS_CPU, MS_DMA3, MS_DMA, MS_USB} smd_mst_t;
    // Whole registered state of the top module.
    typedef struct packed {
        logic remap;
        logic [7:0] da_en;
        logic [7:0] db_en;
        logic [7:0] da_we;
        logic [7:0] db_we;
        logic [7:0][1:0] da_src;
        logic [7:0][1:0] db_src;
        logic [24:0] sa_en;
        logic [24:0] sa_we;
        logic [24:0][1:0] sa_src;
        logic [3:0] rom_en;
        logic [3:0] rom_src;
        logic [3:0] cs_n;
        logic ext_we;
        logic [1:0] ext_src;
        logic [20:0] ext_addr;
        logic ecc1;
        logic ecc4;
    } smd_st_t;
endpackage : smd_pkg

// *** hw/smd_tgt_if.sv ***
// Carrier of one decoded target from a decoder to the top module.
// Assumes one instance per master.
`timescale 1ns/1ps
interface smd_tgt_if;
    import smd_pkg::*;
    smd_kind_t kind;
    logic [4:0] blk;
    logic [1:0] cs;
    modport dec (output kind, output blk, output cs);
    modport top (input kind, input blk, input cs);
endinterface : smd_tgt_if

// *** hw/smd_top.sv ***
// Top of the system memory map decoder: relocation, decode, per-block
// arbitration and registered memory and chip-select strobes.
// Assumes all masters and memories run on mclk_i; a losing master
// holds its request until it sees ready, a refused one sees err.
//
// What this block does
// - Processor 0..00FFFFh selects eight dual RAM blocks.
// - Each dual RAM block serves two accesses.
// - DMA/USB see RAM at relocated addresses.
// - Lowest 192 bytes hold core mapped registers.
// - USB is refused the dual RAM.
// - Of the DMA controllers only controller 3 reaches external space.
// - 010000h..041FFFh selects single RAM blocks.
// - Single RAM block serves one access, serialized.
// - ROM at FE0000h..FFFFFFh while remap clear.
// - Four ROM blocks, processor buses only.
// - Set remap bit moves ROM range external.
// - Hardware reset clears the remap bit.
// - Software reset leaves the remap bit.
// - External space has four chip-select regions, two to five.
// - Each region drives its own select.
// - External port: 16/8 data, 21-bit address.
// - NAND mode offers 1-bit and 4-bit correction.
`timescale 1ns/1ps
`include "smd_defs.svh"
module smd_top
    import smd_pkg::*;
(
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic [3:0] m_req_i,
    input wire logic [3:0] m_we_i,
    input wire logic [23:0] cpu_d_addr_i,
    input wire logic [23:0] cpu_p_addr_i,
    input wire logic [31:0] dma_addr_i,
    input wire logic [1:0] dma_id_i,
    input wire logic [31:0] usb_addr_i,
    input wire logic st3_wr_i,
    input wire logic st3_remap_i,
    input wire logic soft_reset_i,
    input wire logic ext_width8_i,
    input wire logic ext_nand_i,
    input wire logic ext_ecc4_i,
    output logic [3:0] m_ready_o,
    output logic [3:0] m_err_o,
    output logic [3:0] m_mmr_o,
    output logic rom_remap_bit_o,
    output logic [7:0] dar_en_a_o,
    output logic [7:0] dar_en_b_o,
    output logic [7:0] dar_we_a_o,
    output logic [7:0] dar_we_b_o,
    output logic [15:0] dar_src_a_o,
    output logic [15:0] dar_src_b_o,
    output logic [24:0] sar_en_o,
    output logic [24:0] sar_we_o,
    output logic [49:0] sar_src_o,
    output logic [3:0] rom_en_o,
    output logic [3:0] rom_src_o,
    output logic [3:0] ext_region_select_n_o,
    output logic ext_we_o,
    output logic [1:0] ext_src_o,
    output logic [20:0] ext_addr_o,
    output logic ext_ecc1_en_o,
    output logic ext_ecc4_en_o
);
    // ************************************************************
    // Relocation of DMA and USB addresses
    // ************************************************************

    // Maps a DMA/USB byte address onto the processor view.
    function automatic logic [23:0] reloc(input logic [31:0] a);
        logic [23:0] r;
        r = `SMD_GAP_ADDR;
        if (a >= `SMD_DMA_DAR_BASE && a < `SMD_DMA_DAR_END) begin
            r = {8'h00, a[15:0]};
        end else if (a >= `SMD_DMA_SAR_BASE && a < `SMD_DMA_SAR_END) begin
            r = a[23:0] - `SMD_DMA_SAR_OFS;
        end else if (a >= `SMD_DMA_EXT_BASE && a < `SMD_DMA_EXT_END) begin
            case (a[27:24])
                4'h2: r = {2'b10, a[21:0]};
                4'h3: r = {3'b110, a[20:0]};
                4'h4: r = {4'b1110, a[19:0]};
                default: r = {4'b1111, a[19:0]};
            endcase
        end
        return r;
    endfunction : reloc

    smd_st_t st_ff;
    smd_st_t nxt_st;
    logic [23:0] addr_w [4];
    smd_mst_t who_w [4];
    smd_kind_t kind_w [4];
    logic [4:0] blk_w [4];
    logic [1:0] cs_w [4];

    // Addresses and master kinds for the four decoders.
    assign addr_w[0] = cpu_d_addr_i;
    assign addr_w[1] = cpu_p_addr_i;
    assign addr_w[2] = reloc(dma_addr_i);
    assign addr_w[3] = reloc(usb_addr_i);
    assign who_w[0] = MS_CPU;
    assign who_w[1] = MS_CPU;
    assign who_w[2] = (dma_id_i == `SMD_DMA_EXT_ID) ? MS_DMA3 : MS_DMA;
    assign who_w[3] = MS_USB;

    // ************************************************************
    // One decoder per master
    // ************************************************************
    smd_tgt_if tgt [4] ();
    for (genvar g = 0; g < `SMD_N_MST; g++) begin : g_dec
        smd_dec u_dec (
            .addr_i(addr_w[g]),
            .who_i(who_w[g]),
            .remap_i(st_ff.remap),
            .tgt(tgt[g])
        );
        assign kind_w[g] = tgt[g].kind;
        assign blk_w[g] = tgt[g].blk;
        assign cs_w[g] = tgt[g].cs;
    end

    // ************************************************************
    // Arbitration and next state
    // ************************************************************

    // Masters are served in priority order: data bus, program bus,
    // DMA, USB. Strobes last one cycle, so they are cleared first and
    // the partly built copy doubles as the occupancy of each block.
    always_comb begin
        logic [2:0] db;
        logic [4:0] sb;
        logic [1:0] rb;
        db = 3'h0;
        sb = 5'h00;
        rb = 2'h0;
        nxt_st = st_ff;
        nxt_st.da_en = '0;
        nxt_st.db_en = '0;
        nxt_st.sa_en = '0;
        nxt_st.rom_en = '0;
        nxt_st.cs_n = 4'hf;
        nxt_st.ecc1 = 1'b0;
        nxt_st.ecc4 = 1'b0;
        m_ready_o = 4'h0;
        m_err_o = 4'h0;
        m_mmr_o = 4'h0;
        // Software reset is not an input to the remap bit.
        if (st3_wr_i) begin
            nxt_st.remap = st3_remap_i;
        end
        for (int m = 0; m < `SMD_N_MST; m++) begin
            db = blk_w[m][2:0];
            sb = blk_w[m];
            rb = blk_w[m][1:0];
            if (m_req_i[m]) begin
                case (kind_w[m])
                    TK_MMR: begin
                        m_ready_o[m] = 1'b1;
                        m_mmr_o[m] = 1'b1;
                    end
                    TK_DAR: begin
                        // Two ports per block; a third master waits.
                        if (!nxt_st.da_en[db]) begin
                            nxt_st.da_en[db] = 1'b1;
                            nxt_st.da_we[db] = m_we_i[m];
                            nxt_st.da_src[db] = 2'(m);
                            m_ready_o[m] = 1'b1;
                        end else if (!nxt_st.db_en[db]) begin
                            nxt_st.db_en[db] = 1'b1;
                            nxt_st.db_we[db] = m_we_i[m];
                            nxt_st.db_src[db] = 2'(m);
                            m_ready_o[m] = 1'b1;
                        end
                    end
                    TK_SAR: begin
                        // One port per block; losers hold and retry.
                        if (!nxt_st.sa_en[sb]) begin
                            nxt_st.sa_en[sb] = 1'b1;
                            nxt_st.sa_we[sb] = m_we_i[m];
                            nxt_st.sa_src[sb] = 2'(m);
                            m_ready_o[m] = 1'b1;
                        end
                    end
                    TK_ROM: begin
                        // Reads only; one word per block per cycle.
                        if (m_we_i[m]) begin
                            m_err_o[m] = 1'b1;
                        end else if (!nxt_st.rom_en[rb]) begin
                            nxt_st.rom_en[rb] = 1'b1;
                            nxt_st.rom_src[rb] = (m == 1);
                            m_ready_o[m] = 1'b1;
                        end
                    end
                    TK_EXT: begin
                        // One external access at a time.
                        if (nxt_st.cs_n == 4'hf) begin
                            nxt_st.cs_n[cs_w[m]] = 1'b0;
                            nxt_st.ext_we = m_we_i[m];
                            nxt_st.ext_src = 2'(m);
                            nxt_st.ext_addr = ext_width8_i ?
                                addr_w[m][20:0] : addr_w[m][21:1];
                            nxt_st.ecc1 = ext_nand_i && !ext_ecc4_i;
                            nxt_st.ecc4 = ext_nand_i && ext_ecc4_i;
                            m_ready_o[m] = 1'b1;
                        end
                    end
                    default: begin
                        m_err_o[m] = 1'b1;
                    end
                endcase
            end
        end
    end

    // ************************************************************
    // State register
    // ************************************************************

    // Hardware reset maps the ROM back in and drops all strobes.
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_ff <= '0;
            st_ff.remap <= `SMD_REMAP_RST;
            st_ff.cs_n <= 4'hf;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Registered strobes to the memories and the external port.
    assign rom_remap_bit_o = st_ff.remap;
    assign dar_en_a_o = st_ff.da_en;
    assign dar_en_b_o = st_ff.db_en;
    assign dar_we_a_o = st_ff.da_we;
    assign dar_we_b_o = st_ff.db_we;
    assign dar_src_a_o = st_ff.da_src;
    assign dar_src_b_o = st_ff.db_src;
    assign sar_en_o = st_ff.sa_en;
    assign sar_we_o = st_ff.sa_we;
    assign sar_src_o = st_ff.sa_src;
    assign rom_en_o = st_ff.rom_en;
    assign rom_src_o = st_ff.rom_src;
    assign ext_region_select_n_o = st_ff.cs_n;
    assign ext_we_o = st_ff.ext_we;
    assign ext_src_o = st_ff.ext_src;
    assign ext_addr_o = st_ff.ext_addr;
    assign ext_ecc1_en_o = st_ff.ecc1;
    assign ext_ecc4_en_o = st_ff.ecc4;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);

    // Software write that sets the remap bit.
    sequence s_remap_set;
        st3_wr_i && st3_remap_i;
    endsequence
    // Program bus access granted in the top of the space.
    sequence s_top_read;
        m_req_i[1] && addr_w[1] >= `SMD_ROM_BASE && m_ready_o[1];
    endsequence

    a_usb_no_dar: assert property (
        (m_req_i[3] && usb_addr_i >= `SMD_DMA_DAR_BASE
            && usb_addr_i < `SMD_DMA_DAR_END) |-> m_err_o[3]
            ##1 (dar_src_a_o[7:6] != 2'h3 || !dar_en_a_o[3]))
        else $error("USB reached dual RAM.");

    a_dma_ext_only3: assert property (
        (m_req_i[2] && dma_id_i != 2'h3 && dma_addr_i >= `SMD_DMA_EXT_BASE
            && dma_addr_i < 32'h050e_0000) |-> m_err_o[2] && !m_ready_o[2])
        else $error("Non-3 DMA routed to external space.");

    a_remap_moves: assert property (
        s_remap_set ##1 (!st3_wr_i and s_top_read)
            |=> ext_region_select_n_o == 4'h7 && rom_en_o == 4'h0)
        else $error("Remapped ROM range did not go to region five.");

    a_rst_clear: assert property (
        $rose(nrst_i) |-> !rom_remap_bit_o)
        else $error("Remap bit not clear after reset.");

    a_soft_keep: assert property (
        (soft_reset_i && !st3_wr_i) |=> $stable(rom_remap_bit_o))
        else $error("Software reset changed the remap bit.");

    a_sar_single: assert property (
        (m_req_i[0] && m_req_i[1] && kind_w[0] == TK_SAR
            && kind_w[1] == TK_SAR && blk_w[0] == blk_w[1])
            |-> m_ready_o[0] && !m_ready_o[1])
        else $error("Single RAM block granted twice.");

    a_dar_dual: assert property (
        (m_req_i[0] && m_req_i[1] && !m_req_i[2] && kind_w[0] == TK_DAR
            && kind_w[1] == TK_DAR && blk_w[0] == blk_w[1])
            |-> m_ready_o[0] && m_ready_o[1] ##1
            dar_en_a_o[$past(blk_w[0][2:0])]
            && dar_en_b_o[$past(blk_w[0][2:0])])
        else $error("Dual RAM block refused a second access.");

    a_rom_zero_wait: assert property (
        (m_req_i[1] && !m_req_i[0] && !m_we_i[1] && !rom_remap_bit_o
            && addr_w[1] >= `SMD_ROM_BASE)
            |-> m_ready_o[1] ##1 rom_en_o[$past(addr_w[1][16:15])])
        else $error("ROM read not served in one cycle.");

    a_gap_quiet: assert property (
        (m_req_i[0] && addr_w[0] >= `SMD_SAR_END
            && addr_w[0] < `SMD_CS2_BASE) |-> m_err_o[0]
            ##1 ext_region_select_n_o == 4'hf)
        else $error("Gap address selected a target.");

    a_cs_region: assert property (
        (m_req_i[0] && addr_w[0] >= `SMD_CS3_BASE
            && addr_w[0] < `SMD_CS4_BASE) |=> ext_region_select_n_o == 4'hd)
        else $error("Region three select not driven.");
endmodule : smd_top

// *** tb/smd_mst_bfm.sv ***
// Model of one bus master that faces the memory map decoder.
// Assumes requests may be taken on any rising edge of mclk_i.
`timescale 1ns/1ps
module smd_mst_bfm (
    input wire logic mclk_i,
    input wire logic ready_i,
    input wire logic err_i,
    output logic req_o,
    output logic we_o,
    output logic [31:0] addr_o
);
    // ****************************************************************
    // Request handshake
    // ****************************************************************

    // Lines start idle so the decoder sees no request at time zero.
    initial begin
        req_o = 1'b0;
        we_o = 1'b0;
        addr_o = 32'h0;
    end

    // Holds one request until a grant or a refusal is seen at an edge, or 41 edges pass.
    task automatic access(input logic [31:0] a, input logic w,
                          output logic rdy, output logic er, output int n);
        n = 0;
        req_o = 1'b1;
        we_o = w;
        addr_o = a;
        // The answer is read at the edge itself, before other masters move.
        @(posedge mclk_i);
        while (ready_i !== 1'b1 && err_i !== 1'b1 && n < 40) begin
            n++;
            @(posedge mclk_i);
        end
        rdy = ready_i;
        er = err_i;
        #1;
        // Released lines show the inverse so stale values never match.
        req_o = 1'b0;
        we_o = ~w;
        addr_o = ~a;
    endtask : access
endmodule : smd_mst_bfm

// *** tb/smd_top_test.sv ***
// Self-checking bench of the system memory map decoder.
// Assumes smd_top with plain ports and one master model per port.
`timescale 1ns/1ps
module smd_top_test;
    logic mclk_i;
    logic nrst_i;
    logic [1:0] dma_id;
    logic st3_wr, st3_val, soft_rst, w8, nand_md, ecc4;
    wire logic [3:0] req, we, rdy, err, mmr, rome, roms, sel;
    wire logic [31:0] ad [4];
    wire logic [7:0] dae, dbe;
    wire logic [24:0] sae;
    wire logic rmp, ewe, ec1, ec4;
    wire logic [20:0] xa;
    wire logic [7:0] dwa, dwb;
    wire logic [15:0] dsa, dsb;
    wire logic [24:0] swe;
    wire logic [49:0] ssr;
    wire logic [1:0] esr;
    logic mmr_seen;
    logic r0, e0, r1, e1;
    int n0, n1;
    int miscompares = 0;
    int total_checks = 0;
    int cyc = 0;
    logic [23:0] base [4] = '{24'h800000, 24'hc00000, 24'he00000,
                              24'hf00000};
    logic [31:0] gap [3] = '{32'h042000, 32'h060000, 32'h7ffffe};

    // ****************************************************************
    // Clock, masters and design
    // ****************************************************************

    // Free running clock of 100 ns.
    initial begin
        mclk_i = 1'b0;
        forever #50 mclk_i = ~mclk_i;
    end

    // One master model per request port.
    for (genvar g = 0; g < 4; g++) begin : g_m
        smd_mst_bfm u (.mclk_i(mclk_i), .ready_i(rdy[g]), .err_i(err[g]),
            .req_o(req[g]), .we_o(we[g]), .addr_o(ad[g]));
    end

    smd_top DUT (.mclk_i(mclk_i), .nrst_i(nrst_i), .m_req_i(req),
        .m_we_i(we), .cpu_d_addr_i(ad[0][23:0]),
        .cpu_p_addr_i(ad[1][23:0]), .dma_addr_i(ad[2]),
        .dma_id_i(dma_id), .usb_addr_i(ad[3]), .st3_wr_i(st3_wr),
        .st3_remap_i(st3_val), .soft_reset_i(soft_rst),
        .ext_width8_i(w8), .ext_nand_i(nand_md), .ext_ecc4_i(ecc4),
        .m_ready_o(rdy), .m_err_o(err), .m_mmr_o(mmr),
        .rom_remap_bit_o(rmp), .dar_en_a_o(dae), .dar_en_b_o(dbe),
        .dar_we_a_o(dwa), .dar_we_b_o(dwb), .dar_src_a_o(dsa),
        .dar_src_b_o(dsb), .sar_en_o(sae), .sar_we_o(swe),
        .sar_src_o(ssr), .rom_en_o(rome), .rom_src_o(roms),
        .ext_region_select_n_o(sel), .ext_we_o(ewe),
        .ext_src_o(esr), .ext_addr_o(xa), .ext_ecc1_en_o(ec1),
        .ext_ecc4_en_o(ec4));

    // Remembers the register hit flag of the data bus at each edge where it requests.
    always @(posedge mclk_i) begin
        if (req[0]) begin
            mmr_seen <= mmr[0];
        end
    end

    // Cuts a hang short well after the expected run length.
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            miscompares++;
            report_and_stop();
        end
    end

    // ****************************************************************
    // Helpers
    // ****************************************************************

    // Expected active-low region selects for a processor address.
    function automatic logic [3:0] exp_sel(input logic [23:0] a,
                                           input logic rm);
        if (a >= 24'hfe0000 && !rm) return 4'hf;
        if (a >= 24'hf00000) return 4'h7;
        if (a >= 24'he00000) return 4'hb;
        if (a >= 24'hc00000) return 4'hd;
        if (a >= 24'h800000) return 4'he;
        return 4'hf;
    endfunction : exp_sel

    task automatic chk(input logic [63:0] got, input logic [63:0] exp,
                       input string what);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: %s got %h exp %h", $time, what, got,
                     exp);
        end
    endtask : chk

    task automatic acc(input int m, input logic [31:0] a, input logic w,
                       output logic r, output logic e, output int n);
        case (m)
            0: g_m[0].u.access(a, w, r, e, n);
            1: g_m[1].u.access(a, w, r, e, n);
            2: g_m[2].u.access(a, w, r, e, n);
            default: g_m[3].u.access(a, w, r, e, n);
        endcase
    endtask : acc

    // Uncontended access: granted or refused at once, as expected.
    task automatic one(input int m, input logic [31:0] a, input logic w,
                       input logic er);
        acc(m, a, w, r0, e0, n0);
        chk({r0, e0, n0[5:0]}, {!er, er, 6'h0}, "grant or refusal");
    endtask : one

    task automatic idle();
        @(posedge mclk_i);
        #1;
    endtask : idle

    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    // ****************************************************************
    // Main sequence
    // ****************************************************************

    // Walks through the map in both views, then the remap bit.
    initial begin
        logic [31:0] a;
        logic w;
        nrst_i = 1'b0;
        dma_id = 2'h0;
        st3_wr = 1'b0;
        st3_val = 1'b0;
        soft_rst = 1'b0;
        w8 = 1'b0;
        nand_md = 1'b0;
        ecc4 = 1'b0;
        void'($urandom(9));
        repeat (10) @(posedge mclk_i);
        #1;
        nrst_i = 1'b1;
        chk({rmp, sel}, {1'b0, 4'hf}, "state after reset");
        for (int b = 0; b < 8; b++) begin
            a = b * 32'h2000 + 32'hc0 + $urandom % 32'h1f40;
            w = 1'($urandom % 2);
            one(0, a, w, 1'b0);
            chk(dae, 8'h1 << b, "dual block cpu");
            chk({dwa[b], dsa[2*b +: 2]}, {w, 2'h0}, "dual owner cpu");
            idle();
            dma_id = 2'($urandom % 4);
            one(2, a + 32'h10000, w, 1'b0);
            chk(dae, 8'h1 << b, "dual block dma");
            chk({dwa[b], dsa[2*b +: 2]}, {w, 2'h2}, "dual owner dma");
            idle();
            one(3, a + 32'h10000, w, 1'b1);
            chk(dae, 8'h0, "dual block usb");
            idle();
        end
        one(0, $urandom % 32'hc0, 1'b0, 1'b0);
        chk({mmr_seen, dae}, {1'b1, 8'h0}, "register hit");
        idle();
        for (int b = 0; b < 25; b++) begin
            a = 32'h10000 + b * 32'h2000 + $urandom % 32'h2000;
            one(1, a, 1'($urandom % 2), 1'b0);
            chk(sae, 25'h1 << b, "single block cpu");
            idle();
            one(3, a + 32'h80000, 1'b1, 1'b0);
            chk(sae, 25'h1 << b, "single block usb");
            chk({swe[b], ssr[2*b +: 2]}, 3'h7, "single owner usb");
            idle();
        end
        fork
            acc(0, 32'h6100, 1'b1, r0, e0, n0);
            acc(1, 32'h6100, 1'b0, r1, e1, n1);
        join
        chk({r0, r1, n1[1:0]}, 4'b1100, "dual same cycle");
        chk({dae, dbe}, 16'h0808, "dual ports a and b");
        chk({dwa[3], dsa[7:6], dwb[3], dsb[7:6]}, 6'b100001, "owners");
        idle();
        fork
            acc(0, 32'h20010, 1'b1, r0, e0, n0);
            acc(1, 32'h20010, 1'b0, r1, e1, n1);
        join
        chk({r0, r1, n0[1:0], n1[1:0]}, 6'b110001, "serialized");
        chk(sae, 25'h100, "single second grant");
        idle();
        for (int k = 0; k < 4; k++) begin
            a = 32'hfe0000 + k * 32'h8000 + $urandom % 32'h8000;
            one(k % 2, a, 1'b0, 1'b0);
            chk({rome, roms[k]}, {4'h1 << k, k % 2 == 1}, "rom");
            idle();
        end
        one(0, 32'hfe0000, 1'b1, 1'b1);
        idle();
        one(2, 32'h050e0000, 1'b0, 1'b1);
        idle();
        for (int i = 0; i < 12; i++) begin
            a = base[i % 4] + $urandom % 32'h10000;
            w = 1'($urandom % 2);
            w8 = 1'($urandom % 2);
            nand_md = 1'($urandom % 2);
            ecc4 = 1'($urandom % 2);
            one(0, a, w, 1'b0);
            chk(sel, exp_sel(a[23:0], 1'b0), "region select");
            chk({ewe, xa}, {w, w8 ? a[20:0] : a[21:1]}, "ext addr");
            chk({ec4, ec1}, nand_md ? (ecc4 ? 2'b10 : 2'b01) : 2'b00,
                "ecc");
            idle();
            chk(sel, 4'hf, "select released");
        end
        for (int id = 0; id < 4; id++) begin
            dma_id = 2'(id);
            one(2, 32'h02000000 + $urandom % 32'h10000, 1'b0, id != 3);
            chk(sel, id == 3 ? 4'he : 4'hf, "dma external");
            chk(esr, id == 3 ? 2'h2 : 2'h0, "external owner");
            idle();
        end
        foreach (gap[j]) begin
            one(0, gap[j], 1'b0, 1'b1);
            chk({sel, sae, dae}, {4'hf, 33'h0}, "gap");
            idle();
        end
        st3_val = 1'b1;
        st3_wr = 1'b1;
        idle();
        st3_wr = 1'b0;
        chk(rmp, 1'b1, "remap set");
        one(1, 32'hfe0000 + $urandom % 32'h20000, 1'b0, 1'b0);
        chk({sel, rome}, {4'h7, 4'h0}, "rom range external");
        idle();
        soft_rst = 1'b1;
        repeat (3) idle();
        soft_rst = 1'b0;
        chk(rmp, 1'b1, "remap after soft reset");
        nrst_i = 1'b0;
        #1;
        chk(rmp, 1'b0, "remap in reset");
        idle();
        nrst_i = 1'b1;
        one(1, 32'hffff00, 1'b0, 1'b0);
        chk(rome, 4'h8, "rom back after reset");
        report_and_stop();
    end
endmodule : smd_top_test
